//--- rtl/pss_scan_sequencer.v
/*
 * Scan-cycle sequencer of a stored-program logic controller: program store,
 * fetch/execute loop, input and output image refresh, scan-time statistics.
 * Holds a 64-step program store, 16 input and 8 output image bits, 16 relays
 * and the three scan-time registers behind a plain strobe register port.
 * Assumes register strobes and terminal inputs synchronous to clk_sys, and
 * a program loaded while stopped, since the store has no reset value.
 */
// Local design decisions: the strobed register port and the register addresses.
// Functional notes
// - Steps run upward from zero; after the end instruction execution restarts at zero.
// - Within a ladder block evaluation goes left to right, then top to bottom.
// - Each instruction is fetched singly, executed, devices updated before next fetch.
// - End instruction triggers end processing: timer update and self-diagnostics, then step zero.
// - All input terminals are sampled together into the input image before step zero.
// - After end, the whole output image goes to output terminals in one batch.
// - Input contacts read the input image, never the live terminals.
// - Output contacts read the output image, not the output terminals.
// - Output coils write only the output image; terminals change at next refresh.
// - An input change reaches a dependent output within one to two scans.
// - The interval between consecutive end instructions is measured in 10 ms units.
// - Minimum, present and maximum scan times are kept in readable registers.
// - Recorded scan time is accurate to plus or minus one unit.
// - Scan length follows the instructions executed; no fixed scan period.
// - One scan is program execution from step zero plus end processing time.
// - Numbers are held in binary; each four bits form one hex digit.
// - On stop, outputs are saved and forced off; other data kept, refresh continues. A stop first seen at input refresh clears running without the save.
// - Data registers, scan-time ones included, are 16 bits with sign in the MSB.
`timescale 1ns/10ps
`default_nettype none
`include "pss_defines.vh"

module pss_scan_sequencer #(
    parameter TICK_CYCLES = `PSS_TICK_CYCLES
) (
    input wire clk_sys,
    input wire srst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [15:0] in_term,
    output reg [7:0] out_term,
    output wire running
);

    localparam [2:0] ST_IN_REFRESH = 3'd0;
    localparam [2:0] ST_FETCH = 3'd1;
    localparam [2:0] ST_EXEC = 3'd2;
    localparam [2:0] ST_END_PROC = 3'd3;
    localparam [2:0] ST_OUT_REFRESH = 3'd4;

    // Prescaler is 21 bits; the default 10 ms count fits with room to spare
    localparam integer TICK_LAST_I = TICK_CYCLES - 1;
    localparam [20:0] TICK_LAST = TICK_LAST_I[20:0];

    // Sequencer state, program store and control
    reg [2:0] state_q;
    reg [5:0] pc_q;
    reg [15:0] instr_q;
    reg [15:0] prog_mem [0:63];
    reg [5:0] prog_addr_q;
    reg run_q;
    reg running_q;
    reg diag_err_q;
    reg meas_valid_q;
    reg acc_q;

    // Images and relays
    reg [15:0] in_img_q;
    reg [7:0] out_img_q;
    reg [7:0] out_saved_q;
    reg [15:0] relay_q;

    // Scan timing
    reg [20:0] tick_cnt_q;
    reg [15:0] scan_cnt_q;
    reg [15:0] scan_min_q;
    reg [15:0] scan_present_q;
    reg [15:0] scan_max_q;

    wire [3:0] opcode = instr_q[15:12];
    wire [1:0] dev_type = instr_q[5:4];
    wire [3:0] dev_idx = instr_q[3:0];
    wire is_end = (opcode == `PSS_OP_END);
    wire inv_op = (opcode == `PSS_OP_LDI) || (opcode == `PSS_OP_ANI) ||
                  (opcode == `PSS_OP_ORI);
    reg operand;
    reg [15:0] rdata_d;

    // Write decodes; program loads are refused while running
    wire wr_ctrl = reg_wr && (reg_addr == `PSS_REG_CTRL);
    wire wr_prog_addr = reg_wr && (reg_addr == `PSS_REG_PROG_ADDR);
    wire wr_prog_data = reg_wr && (reg_addr == `PSS_REG_PROG_DATA) && !running_q;

    // Output refresh value per terminal: the image while running, off while stopped
    wire [7:0] out_next;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_out
            assign out_next[gi] = running_q & out_img_q[gi];
        end
    endgenerate

    assign running = running_q;

    // Operand fetch only from image memories and relays
    always @* begin
        case (dev_type)
            `PSS_DEV_IN: operand = in_img_q[dev_idx];
            `PSS_DEV_OUT: operand = out_img_q[dev_idx[2:0]];
            `PSS_DEV_RELAY: operand = relay_q[dev_idx];
            default: operand = 1'b0;
        endcase
    end

    // Program store; loading is accepted only while stopped so a scan never
    // sees a half-written program
    always @(posedge clk_sys) begin
        if (wr_prog_data) begin
            prog_mem[prog_addr_q] <= reg_wdata;
        end
    end

    // Control registers
    always @(posedge clk_sys) begin
        if (srst) begin
            run_q <= `PSS_CTRL_RST;
            prog_addr_q <= 6'h00;
        end else if (reg_wr) begin
            if (wr_ctrl) begin
                run_q <= reg_wdata[`PSS_CTRL_RUN];
            end
            if (wr_prog_addr) begin
                prog_addr_q <= reg_wdata[5:0];
            end
            // A data write steps the load address so a program goes in as a burst
            if (wr_prog_data) begin
                prog_addr_q <= prog_addr_q + 6'h01;
            end
        end
    end

    // Sequencer: input refresh, fetch/execute, end processing, output refresh
    always @(posedge clk_sys) begin
        if (srst) begin
            // Images cleared so the first scan starts from all-off
            state_q <= ST_IN_REFRESH;
            pc_q <= 6'h00;
            instr_q <= 16'h0000;
            acc_q <= 1'b0;
            in_img_q <= 16'h0000;
            out_img_q <= 8'h00;
            out_saved_q <= 8'h00;
            relay_q <= 16'h0000;
            out_term <= 8'h00;
            running_q <= 1'b0;
            diag_err_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IN_REFRESH: begin
                    // Whole input word sampled on one edge
                    in_img_q <= in_term;
                    pc_q <= 6'h00;
                    acc_q <= 1'b0;
                    if (run_q && !running_q) begin
                        // Restore the outputs saved at stop
                        out_img_q <= out_saved_q;
                    end
                    running_q <= run_q;
                    // Stopped: keep refreshing without executing
                    state_q <= run_q ? ST_FETCH : ST_OUT_REFRESH;
                end
                ST_FETCH: begin
                    // One step takes two clocks: fetch, then execute
                    instr_q <= prog_mem[pc_q];
                    state_q <= ST_EXEC;
                end
                ST_EXEC: begin
                    // Sequential list order gives left-to-right, top-to-bottom
                    // Inverting forms flip the operand; a coil on an input is ignored
                    case (opcode)
                        `PSS_OP_LD, `PSS_OP_LDI: acc_q <= operand ^ inv_op;
                        `PSS_OP_AND, `PSS_OP_ANI: acc_q <= acc_q & (operand ^ inv_op);
                        `PSS_OP_OR, `PSS_OP_ORI: acc_q <= acc_q | (operand ^ inv_op);
                        `PSS_OP_OUT: begin
                            if (dev_type == `PSS_DEV_OUT) begin
                                out_img_q[dev_idx[2:0]] <= acc_q;
                            end else if (dev_type == `PSS_DEV_RELAY) begin
                                relay_q[dev_idx] <= acc_q;
                            end
                        end
                        default: acc_q <= acc_q;
                    endcase
                    if (is_end) begin
                        state_q <= ST_END_PROC;
                    end else if (pc_q == 6'h3F) begin
                        // Program ran off the store without an end
                        // Sticky until reset; software sees it in the status register
                        diag_err_q <= 1'b1;
                        state_q <= ST_END_PROC;
                    end else begin
                        pc_q <= pc_q + 6'h01;
                        state_q <= ST_FETCH;
                    end
                end
                ST_END_PROC: begin
                    // Self-diagnostic: stop requested mid-scan is checked here
                    // No timers or counters live in this block, so nothing else updates
                    if (!run_q) begin
                        out_saved_q <= out_img_q;
                        running_q <= 1'b0;
                    end
                    state_q <= ST_OUT_REFRESH;
                end
                ST_OUT_REFRESH: begin
                    // All terminals change on this one edge
                    out_term <= out_next;
                    state_q <= ST_IN_REFRESH;
                end
                default: state_q <= ST_IN_REFRESH;
            endcase
        end
    end

    // Free-running 10 ms prescaler; sampling it at end instructions gives
    // at most one unit of error on each side
    // A shorter TICK_CYCLES shrinks the unit for simulation
    wire tick = (tick_cnt_q == TICK_LAST);
    wire end_hit = (state_q == ST_END_PROC) && running_q;

    always @(posedge clk_sys) begin
        if (srst) begin
            tick_cnt_q <= 21'h000000;
        end else if (tick) begin
            tick_cnt_q <= 21'h000000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 21'h000001;
        end
    end

    // Scan-time statistics, saturating below the sign bit
    // The counter keeps running while stopped, so the first scan after a
    // restart reports the stopped time as well
    always @(posedge clk_sys) begin
        if (srst) begin
            scan_cnt_q <= `PSS_SCAN_RST;
            scan_min_q <= `PSS_SCAN_RST;
            scan_present_q <= `PSS_SCAN_RST;
            scan_max_q <= `PSS_SCAN_RST;
            meas_valid_q <= 1'b0;
        end else if (end_hit) begin
            scan_cnt_q <= tick ? 16'h0001 : `PSS_SCAN_RST;
            scan_present_q <= scan_cnt_q;
            if (!meas_valid_q || scan_cnt_q < scan_min_q) begin
                scan_min_q <= scan_cnt_q;
            end
            if (!meas_valid_q || scan_cnt_q > scan_max_q) begin
                scan_max_q <= scan_cnt_q;
            end
            meas_valid_q <= 1'b1;
        end else if (tick && scan_cnt_q != `PSS_SCAN_SAT) begin
            scan_cnt_q <= scan_cnt_q + 16'h0001;
        end
    end

    // Read mux; unmapped indices read zero
    // Status: bit 0 running, bit 1 diagnostic error, bit 2 measurement valid
    always @* begin
        case (reg_addr)
            `PSS_REG_CTRL: rdata_d = {15'h0000, run_q};
            `PSS_REG_STATUS: rdata_d = {13'h0000, meas_valid_q, diag_err_q, running_q};
            `PSS_REG_PROG_ADDR: rdata_d = {10'h000, prog_addr_q};
            `PSS_REG_SCAN_MIN: rdata_d = scan_min_q;
            `PSS_REG_SCAN_PRESENT: rdata_d = scan_present_q;
            `PSS_REG_SCAN_MAX: rdata_d = scan_max_q;
            `PSS_REG_OUT_IMAGE: rdata_d = {8'h00, out_img_q};
            `PSS_REG_IN_IMAGE: rdata_d = in_img_q;
            default: rdata_d = 16'h0000;
        endcase
    end

    // Data stand only in the cycle after a read, zero otherwise
    always @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule // pss_scan_sequencer
`default_nettype wire

//--- rtl/pss_defines.vh
/*
 * Constants for the scan-cycle sequencer: register indices, field positions,
 * instruction encoding, reset values and scan-time units.
 * Assumes inclusion by bare name from the sequencer source.
 */
`ifndef PSS_DEFINES_VH
`define PSS_DEFINES_VH

// Register indices on the 4-bit register port
`define PSS_REG_CTRL 4'h0
`define PSS_REG_STATUS 4'h1
`define PSS_REG_PROG_ADDR 4'h2
`define PSS_REG_PROG_DATA 4'h3
`define PSS_REG_SCAN_MIN 4'h4
`define PSS_REG_SCAN_PRESENT 4'h5
`define PSS_REG_SCAN_MAX 4'h6
`define PSS_REG_OUT_IMAGE 4'h7
`define PSS_REG_IN_IMAGE 4'h8

// Field positions
`define PSS_CTRL_RUN 0
`define PSS_STAT_RUNNING 0
`define PSS_STAT_DIAG_ERR 1
`define PSS_STAT_MEAS_VALID 2

// Reset values and scan-time saturation limit
`define PSS_CTRL_RST 1'h0
`define PSS_SCAN_RST 16'h0000
`define PSS_SCAN_SAT 16'h7FFF

// Instruction word: [15:12] opcode, [5:4] device type, [3:0] device index
`define PSS_OP_NOP 4'h0
`define PSS_OP_LD 4'h1
`define PSS_OP_LDI 4'h2
`define PSS_OP_AND 4'h3
`define PSS_OP_ANI 4'h4
`define PSS_OP_OR 4'h5
`define PSS_OP_ORI 4'h6
`define PSS_OP_OUT 4'h7
`define PSS_OP_END 4'hF
`define PSS_DEV_IN 2'h0
`define PSS_DEV_OUT 2'h1
`define PSS_DEV_RELAY 2'h2

// Scan time unit and clock rate
`define PSS_UNIT_MS 10
`define PSS_CLK_KHZ 125000
`define PSS_TICK_CYCLES (`PSS_UNIT_MS * `PSS_CLK_KHZ)

`endif

//--- verification/pss_scan_checker.sv
/* Checker for the scan sequencer: register port and terminal timing.
   Assumes it is bound to pss_scan_sequencer and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module pss_scan_checker (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] in_term,
    input wire logic [7:0] out_term,
    input wire logic running
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence stopped_s; (!running)[*3]; endsequence
    sequence quiet_in_s; (!running && $stable(in_term))[*8]; endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data seen without a read");
    unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) > 4'h8
        |-> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    scan_sign_a: assert property ($past(reg_rd) && $past(reg_addr) >= 4'h4
        && $past(reg_addr) <= 4'h6 |-> !reg_rdata[15]) else $error("scan time negative");
    out_batch_a: assert property ($changed(out_term) |=> $stable(out_term)[*3])
        else $error("outputs changed twice within a scan");
    stop_off_a: assert property (stopped_s |-> out_term == 8'h00)
        else $error("outputs on while stopped");
    in_image_a: assert property (quiet_in_s ##0 (reg_rd && reg_addr == 4'h8)
        |=> reg_rdata == $past(in_term)) else $error("input image stale");
    status_run_a: assert property (reg_rd && reg_addr == 4'h1 && $stable(running)
        |=> reg_rdata[0] == $past(running)) else $error("status run bit wrong");
    run_start_a: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[0] && !running
        |-> ##[1:4] running) else $error("run did not start");
endmodule // pss_scan_checker
bind pss_scan_sequencer pss_scan_checker chk_u (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .in_term(in_term), .out_term(out_term), .running(running));
`default_nettype wire

//--- verification/pss_term_model.sv
/* Model of the controller's control terminals: drives input levels.
   Assumes the bench calls set_inputs; levels change just after a clock edge. */
`timescale 1ns/10ps
`default_nettype none
module pss_term_model (
    input wire logic clk_sys,
    output var logic [15:0] in_term,
    input wire logic [7:0] out_term
);
    initial in_term = 16'h0000;
    task automatic set_inputs(input logic [15:0] v);
        @(posedge clk_sys);
        in_term <= v;
    endtask
endmodule // pss_term_model
`default_nettype wire

//--- verification/tb.sv
/* Self-checking bench for the scan sequencer over its register port.
   Assumes the terminal model drives inputs; ticks shortened to 20 cycles. */
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int TICK = 20;
    localparam int SCAN = 13;
    localparam int LONG = 113;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [15:0] reg_rdata;
    wire [15:0] in_term;
    wire [7:0] out_term;
    wire running;
    logic [15:0] rd_q, mn, pr, mx;
    int err_count = 0;
    int cmp_count = 0;
    int n;
    always #4 clk_sys = ~clk_sys;
    pss_scan_sequencer #(.TICK_CYCLES(TICK)) dut_u (.clk_sys(clk_sys), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .in_term(in_term), .out_term(out_term), .running(running));
    pss_term_model term_u (.clk_sys(clk_sys), .in_term(in_term), .out_term(out_term));
    task automatic results();
        $display("checks %0d errors %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    // Bounded wait; running out of cycles counts a mismatch
    task automatic wait_out(input logic [7:0] e, input int lim);
        n = 0;
        while (out_term !== e && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        if (out_term !== e) begin
            err_count++;
            $display("BAD out_term expected %h seen %h", e, out_term);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        for (int a = 4; a <= 7; a++) begin
            rd(a[3:0], rd_q);
            chk("reset_reg", 16'h0000, rd_q);
        end
        rd(4'hF, rd_q);
        chk("unmapped", 16'h0000, rd_q);
        wr(4'h4, 16'h1234);
        rd(4'h4, rd_q);
        chk("min_ro", 16'h0000, rd_q);
        // Y1 reads Y0 back from the image in the same scan
        wr(4'h2, 16'h0000);
        wr(4'h3, 16'h1000);
        wr(4'h3, 16'h7010);
        wr(4'h3, 16'h2010);
        wr(4'h3, 16'h7011);
        wr(4'h3, 16'hF000);
        wr(4'h0, 16'h0001);
        wait_out(8'h02, 4 * SCAN);
        term_u.set_inputs(16'h0001);
        wait_out(8'h01, 3 * SCAN);
        chk("delay_ok", 16'h0001, {15'h0000, n >= SCAN - 3 && n <= 2 * SCAN});
        repeat (400) @(posedge clk_sys);
        rd(4'h4, mn);
        rd(4'h5, pr);
        rd(4'h6, mx);
        chk("present_short", 16'h0001, {15'h0000, pr <= SCAN / TICK + 1});
        chk("min_le_max", 16'h0001, {15'h0000, mn <= pr && pr <= mx});
        rd(4'h1, rd_q);
        chk("status", 16'h0005, rd_q);
        wr(4'h0, 16'h0000);
        wait_out(8'h00, 3 * SCAN);
        repeat (4) @(posedge clk_sys);
        chk("stopped", 16'h0000, {15'h0000, running});
        term_u.set_inputs(16'h00A5);
        repeat (12) @(posedge clk_sys);
        rd(4'h8, rd_q);
        chk("in_image", 16'h00A5, rd_q);
        // Fifty idle steps stretch the scan so its time is measurable
        wr(4'h2, 16'h0004);
        repeat (50) wr(4'h3, 16'h0000);
        wr(4'h3, 16'hF000);
        wr(4'h0, 16'h0001);
        repeat (10 * LONG) @(posedge clk_sys);
        rd(4'h5, pr);
        rd(4'h6, mx);
        chk("present_long", 16'h0001,
            {15'h0000, pr + 1 >= LONG / TICK && pr <= LONG / TICK + 2});
        chk("max_ge", 16'h0001, {15'h0000, mx >= pr});
        chk("out_restart", 16'h0001, {8'h00, out_term});
        results();
    end
endmodule // tb
`default_nettype wire
